// ### rtl/sacc_ctrl.sv
/*
  Successive approximation register and sequencing for an analog-to-digital
  converter built around an external DAC and comparator.
  Assumes the DAC settles and the comparator verdict is valid within one
  clock period, and that start_n is synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - A start sampled low at two consecutive clock edges begins a conversion.
// - Bits are decided one at a time, most significant first.
// - Each trial sets the bit under test to one, higher bits unchanged.
// - DAC below input: the bit under test stays one.
// - DAC above input: the bit under test is cleared.
// - After a decision the next lower bit is tried.
// - An n-bit conversion takes exactly n trials.
// - Each trial lasts one clock period.
// - First trial shows the MSB line low and all other lines high.
// - Each decided bit leaves serially, MSB first, one per clock.
// - The final pattern stays in the register and drives the DAC.
module sacc_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic start_n,
  input wire logic cmp_high,
  output logic [sacc_pkg::SACC_WIDTH-1:0] dac_lines_n,
  output logic [sacc_pkg::SACC_WIDTH-1:0] result,
  output var sacc_pkg::sacc_flags_t flags
);

  sacc_pkg::sacc_state_t state_q;
  sacc_pkg::sacc_state_t state_d;
  logic [sacc_pkg::SACC_WIDTH-1:0] code_q;
  logic [sacc_pkg::SACC_WIDTH-1:0] code_d;
  logic [sacc_pkg::SACC_WIDTH-1:0] lines_q;
  logic [sacc_pkg::SACC_WIDTH-1:0] lines_d;
  logic [sacc_pkg::SACC_WIDTH-1:0] result_q;
  logic [sacc_pkg::SACC_WIDTH-1:0] result_d;
  logic [sacc_pkg::SACC_IDX_W-1:0] idx_q;
  logic [sacc_pkg::SACC_IDX_W-1:0] idx_d;
  sacc_pkg::sacc_flags_t flags_q;
  sacc_pkg::sacc_flags_t flags_d;
  logic start_req;
  logic trial_on;
  logic start_take;
  logic last_trial;
  logic bit_keep;
  logic [sacc_pkg::SACC_IDX_W-1:0] next_idx;
  logic [sacc_pkg::SACC_WIDTH-1:0] decided_code;

  // ---------------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------------
  // True while the register is stepping through its trials.
  function automatic logic sacc_in_trial(input sacc_pkg::sacc_state_t st);
    return st == sacc_pkg::SACC_CONV;
  endfunction : sacc_in_trial

  // True in the states from which a new conversion may begin.
  function automatic logic sacc_can_start(input sacc_pkg::sacc_state_t st);
    return (st == sacc_pkg::SACC_IDLE) || (st == sacc_pkg::SACC_DONE);
  endfunction : sacc_can_start

  // True when the bit under test is the least significant one.
  function automatic logic sacc_is_last(input logic [sacc_pkg::SACC_IDX_W-1:0] idx);
    return idx == sacc_pkg::SACC_IDX_LSB;
  endfunction : sacc_is_last

  // Returns the code with the bit under test replaced by the verdict.
  function automatic logic [sacc_pkg::SACC_WIDTH-1:0] sacc_place_bit(
    input logic [sacc_pkg::SACC_WIDTH-1:0] code,
    input logic [sacc_pkg::SACC_IDX_W-1:0] idx,
    input logic keep
  );
    logic [sacc_pkg::SACC_WIDTH-1:0] res;
    res = code;
    res[idx] = keep;
    return res;
  endfunction : sacc_place_bit

  // Returns the next lower bit position.
  function automatic logic [sacc_pkg::SACC_IDX_W-1:0] sacc_lower(
    input logic [sacc_pkg::SACC_IDX_W-1:0] idx
  );
    return idx - 1'b1;
  endfunction : sacc_lower

  // ---------------------------------------------------------------------
  // Shared trial decode
  // ---------------------------------------------------------------------
  always_comb begin
    trial_on = sacc_in_trial(state_q);
    // A start is acted on only from idle or done; the detector is gated as well.
    start_take = start_req & sacc_can_start(state_q);
    last_trial = sacc_is_last(idx_q);
    // keep bit when DAC below input
    bit_keep = ~cmp_high;
    // clear bit when DAC above input
    decided_code = sacc_place_bit(code_q, idx_q, bit_keep);
    next_idx = sacc_lower(idx_q);
  end

  // ---------------------------------------------------------------------
  // Start qualification
  // ---------------------------------------------------------------------
  // blocked while converting
  sacc_start_det u_start (
    .clk(clk),
    .srst(srst),
    .start_n(start_n),
    .enable(~trial_on),
    .start_req(start_req)
  );

  // ---------------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------------
  // The unused encoding falls back to idle.
  always_comb begin
    state_d = state_q;
    case (state_q)
      sacc_pkg::SACC_IDLE, sacc_pkg::SACC_DONE: begin
        if (start_take) begin
          state_d = sacc_pkg::SACC_CONV;
        end
      end
      sacc_pkg::SACC_CONV: begin
        if (last_trial) begin
          state_d = sacc_pkg::SACC_DONE;
        end
      end
      default: begin
        state_d = sacc_pkg::SACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= sacc_pkg::SACC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------------
  // Bit index
  // ---------------------------------------------------------------------
  // The index parks at the MSB after reset and is reloaded on every start.
  always_comb begin
    idx_d = idx_q;
    case (state_q)
      sacc_pkg::SACC_IDLE, sacc_pkg::SACC_DONE: begin
        if (start_take) begin
          idx_d = sacc_pkg::SACC_IDX_MSB;
        end
      end
      sacc_pkg::SACC_CONV: begin
        if (!last_trial) begin
          idx_d = next_idx;
        end
      end
      default: begin
        idx_d = sacc_pkg::SACC_IDX_MSB;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      idx_q <= sacc_pkg::SACC_IDX_MSB;
    end else begin
      idx_q <= idx_d;
    end
  end

  // ---------------------------------------------------------------------
  // Trial code
  // ---------------------------------------------------------------------
  always_comb begin
    code_d = code_q;
    case (state_q)
      sacc_pkg::SACC_IDLE, sacc_pkg::SACC_DONE: begin
        if (start_take) begin
          code_d = sacc_pkg::sacc_set_bit(sacc_pkg::SACC_CODE_RST, sacc_pkg::SACC_IDX_MSB);
        end
      end
      sacc_pkg::SACC_CONV: begin
        if (last_trial) begin
          code_d = decided_code;
        end else begin
          code_d = sacc_pkg::sacc_set_bit(decided_code, next_idx);
        end
      end
      default: begin
        code_d = sacc_pkg::SACC_CODE_RST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      code_q <= sacc_pkg::SACC_CODE_RST;
    end else begin
      code_q <= code_d;
    end
  end

  // ---------------------------------------------------------------------
  // DAC lines
  // ---------------------------------------------------------------------
  // Lines follow the next code so that they move at the same edge as the register.
  always_comb begin
    lines_d = ~code_d;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lines_q <= sacc_pkg::SACC_LINES_RST;
    end else begin
      lines_q <= lines_d;
    end
  end

  // ---------------------------------------------------------------------
  // Converted result
  // ---------------------------------------------------------------------
  // The result updates only on the LSB decision, so it holds across idle.
  always_comb begin
    result_d = result_q;
    if (trial_on && last_trial) begin
      result_d = decided_code;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      result_q <= sacc_pkg::SACC_CODE_RST;
    end else begin
      result_q <= result_d;
    end
  end

  // ---------------------------------------------------------------------
  // Status and serial flags
  // ---------------------------------------------------------------------
  // The serial bit stays put between decisions; only the valid pulse clears.
  always_comb begin
    flags_d = flags_q;
    flags_d.ser_valid = 1'b0;
    case (state_q)
      sacc_pkg::SACC_IDLE, sacc_pkg::SACC_DONE: begin
        if (start_take) begin
          flags_d.busy = 1'b1;
          flags_d.done = 1'b0;
        end
      end
      sacc_pkg::SACC_CONV: begin
        flags_d.ser_bit = bit_keep;
        flags_d.ser_valid = 1'b1;
        if (last_trial) begin
          flags_d.busy = 1'b0;
          flags_d.done = 1'b1;
        end
      end
      default: begin
        flags_d = sacc_pkg::SACC_FLAGS_RST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flags_q <= sacc_pkg::SACC_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // Every output comes straight from its register.
  assign dac_lines_n = lines_q;
  assign result = result_q;
  assign flags = flags_q;

endmodule : sacc_ctrl

`default_nettype wire

// ### rtl/sacc_pkg.sv
/*
  Shared constants, state encoding and carrier types for the successive
  approximation conversion control.
  Assumes a single clock domain and a synchronous active-high reset.
*/
package sacc_pkg;

  // ---------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned SACC_WIDTH = 10;
  localparam int unsigned SACC_IDX_W = 4;
  localparam logic [SACC_WIDTH-1:0] SACC_CODE_RST = 10'h000;
  localparam logic [SACC_WIDTH-1:0] SACC_LINES_RST = 10'h3ff;
  localparam logic [SACC_IDX_W-1:0] SACC_IDX_MSB = 4'h9;
  localparam logic [SACC_IDX_W-1:0] SACC_IDX_LSB = 4'h0;

  // ---------------------------------------------------------------------
  // States and carriers
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    SACC_IDLE,
    SACC_CONV,
    SACC_DONE
  } sacc_state_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic ser_bit;
    logic ser_valid;
  } sacc_flags_t;

  localparam sacc_flags_t SACC_FLAGS_RST = '{busy: 1'b0, done: 1'b0, ser_bit: 1'b0, ser_valid: 1'b0};

  // Returns the code with the given bit forced to one.
  function automatic logic [SACC_WIDTH-1:0] sacc_set_bit(
    input logic [SACC_WIDTH-1:0] code,
    input logic [SACC_IDX_W-1:0] idx
  );
    logic [SACC_WIDTH-1:0] res;
    res = code;
    res[idx] = 1'b1;
    return res;
  endfunction : sacc_set_bit

endpackage : sacc_pkg

// ### rtl/sacc_start_det.sv
/*
  Start request qualifier for the conversion control.
  Assumes start_n is synchronous to clk and that enable is high whenever a
  new conversion may be accepted.
*/
`timescale 1ns/10ps
`default_nettype none

module sacc_start_det (
  input wire logic clk,
  input wire logic srst,
  input wire logic start_n,
  input wire logic enable,
  output logic start_req
);

  logic low_q;
  logic low_d;
  logic armed_q;
  logic armed_d;
  logic req_q;
  logic req_d;
  logic accept;

  // ---------------------------------------------------------------------
  // Qualification
  // ---------------------------------------------------------------------
  always_comb begin
    low_d = ~start_n;
    accept = ~start_n & low_q & armed_q & enable;
    // A held-low start fires once; it must go high again to re-arm.
    armed_d = armed_q;
    if (start_n) begin
      armed_d = 1'b1;
    end else if (accept) begin
      armed_d = 1'b0;
    end
    req_d = accept;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      low_q <= 1'b0;
      armed_q <= 1'b1;
      req_q <= 1'b0;
    end else begin
      low_q <= low_d;
      armed_q <= armed_d;
      req_q <= req_d;
    end
  end

  assign start_req = req_q;

endmodule : sacc_start_det

`default_nettype wire

// ### tb/sacc_ctrl_checker.sv
/* Port assertions for sacc_ctrl.
   Assumes one clock and the synchronous reset srst. */
`timescale 1ns/10ps
`default_nettype none
module sacc_ctrl_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic start_n,
  input wire logic cmp_high,
  input wire logic [sacc_pkg::SACC_WIDTH-1:0] dac_lines_n,
  input wire logic [sacc_pkg::SACC_WIDTH-1:0] result,
  input wire sacc_pkg::sacc_flags_t flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_start_first: assert property ($rose(flags.busy) |-> !$past(start_n, 2) && !$past(start_n, 3) && dac_lines_n == 10'h1ff)
    else $error("bad start");
  a_trial_count: assert property ($rose(flags.busy) |-> flags.busy[*8] ##1 flags.busy[*2] ##1 (!flags.busy && flags.done))
    else $error("bad length");
  a_first_decide: assert property ($rose(flags.busy) |=> dac_lines_n[9] == $past(cmp_high) && dac_lines_n[8:0] == 9'h0ff)
    else $error("bad trial");
  a_ser_valid: assert property (flags.busy |=> flags.ser_valid)
    else $error("no bit");
  a_ser_cause: assert property (flags.ser_valid |-> $past(flags.busy))
    else $error("stray bit");
  a_keep_bit: assert property (flags.busy && !cmp_high |=> flags.ser_bit)
    else $error("bit lost");
  a_clear_bit: assert property (flags.busy && cmp_high |=> !flags.ser_bit)
    else $error("bit kept");
  a_final_code: assert property (flags.done |-> dac_lines_n == ~result)
    else $error("bad final");
  a_done_hold: assert property (flags.done && $past(start_n) |=> flags.done)
    else $error("done lost");
  a_no_retrig: assert property ($fell(flags.busy) |=> !flags.busy)
    else $error("retrigger");
  c_done: cover property ($rose(flags.done));
  c_busy_start: cover property (flags.busy && !start_n);
  c_back: cover property (flags.done ##1 $rose(flags.busy));
endmodule : sacc_ctrl_checker
bind sacc_ctrl sacc_ctrl_checker chk_u (.clk(clk), .srst(srst), .start_n(start_n), .cmp_high(cmp_high),
  .dac_lines_n(dac_lines_n), .result(result), .flags(flags));
`default_nettype wire

// ### tb/sacc_dac_cmp_model.sv
/* Ideal DAC and comparator closing the loop.
   The analog input is given by the bench as a code. */
`timescale 1ns/10ps
`default_nettype none
module sacc_dac_cmp_model (
  input wire logic [sacc_pkg::SACC_WIDTH-1:0] dac_lines_n,
  input wire logic [sacc_pkg::SACC_WIDTH-1:0] vin,
  output logic cmp_high
);
  // High while the DAC level lies above the input.
  assign cmp_high = (~dac_lines_n) > vin;
endmodule : sacc_dac_cmp_model
`default_nettype wire

// ### tb/sacc_ctrl_tb.sv
/* Self-checking bench for sacc_ctrl with an ideal DAC loop.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("mismatch %s exp %h got %h", n, e, g); end end
module sacc_ctrl_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic start_n = 1'b1;
  logic cmp_high;
  logic [9:0] vin = 10'h000;
  logic [9:0] dac_lines_n;
  logic [9:0] result;
  logic [9:0] ser_q;
  sacc_pkg::sacc_flags_t flags;
  int err_total = 0;
  int n_compared = 0;
  int nbits;
  always #4 clk = ~clk;
  sacc_ctrl dut_u (.clk(clk), .srst(srst), .start_n(start_n), .cmp_high(cmp_high),
    .dac_lines_n(dac_lines_n), .result(result), .flags(flags));
  sacc_dac_cmp_model dac_u (.dac_lines_n(dac_lines_n), .vin(vin), .cmp_high(cmp_high));
  function automatic logic [9:0] sar_exp(input logic [9:0] v);
    logic [9:0] c;
    c = 10'h000;
    for (int i = 9; i >= 0; i--) begin
      c[i] = 1'b1;
      if (c > v) c[i] = 1'b0;
    end
    return c;
  endfunction : sar_exp
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // Start held two edges, then one bit a clock; retrig pulses start mid-run.
  task automatic conv(input logic [9:0] v, input bit retrig);
    @(posedge clk);
    vin <= v;
    start_n <= 1'b0;
    repeat (2) @(posedge clk);
    start_n <= 1'b1;
    nbits = 0;
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      if (retrig && i == 2) start_n <= 1'b0;
      if (retrig && i == 5) start_n <= 1'b1;
      #1;
      if (i == 0) `CHK("first", 10'h1ff, dac_lines_n)
      if (flags.ser_valid === 1'b1) begin
        ser_q = {ser_q[8:0], flags.ser_bit};
        nbits++;
      end
    end
    `CHK("bits", 10, nbits)
    `CHK("serial", sar_exp(v), ser_q)
    `CHK("result", sar_exp(v), result)
    `CHK("lines", ~sar_exp(v), dac_lines_n)
    repeat (2) @(posedge clk);
    #1;
    `CHK("hold", 2'b01, {flags.busy, flags.done})
  endtask : conv
  initial begin
    void'($urandom(32'hd716));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    conv(10'h000, 1'b0);
    @(posedge clk);
    start_n <= 1'b0;
    @(posedge clk);
    start_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("short", 2'b01, {flags.busy, flags.done})
    conv(10'h3ff, 1'b1);
    conv(10'h200, 1'b0);
    conv(10'h1ff, 1'b1);
    repeat (20) conv(10'($urandom), 1'($urandom));
    final_report();
  end
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    final_report();
  end
endmodule : sacc_ctrl_tb
`default_nettype wire
